// File: rtl/port_pin_function_mux.sv
// Port pin function multiplexer with GPIO registers
`timescale 1ns/1ps
module port_pin_function_mux
(
  input  wire logic                                        mclk,
  input  wire logic                                        resetn,
  input  wire logic [pin_mux_pkg::AW-1:0]                  addr,
  input  wire logic [31:0]                                 wdata,
  input  wire logic                                        wr_stb,
  input  wire logic                                        rd_stb,
  output logic      [31:0]                                 rdata,
  input  wire logic [pin_mux_pkg::NUM_PINS-1:0]            pin_in,
  output logic      [pin_mux_pkg::NUM_PINS-1:0]            pin_out,
  output logic      [pin_mux_pkg::NUM_PINS-1:0]            pin_oe_n,
  output logic      [pin_mux_pkg::NUM_PINS-1:0]            pin_pull_en,
  output logic      [pin_mux_pkg::NUM_PINS-1:0]            pin_hidrive,
  input  wire logic [pin_mux_pkg::NUM_ALT-1:0][pin_mux_pkg::NUM_PINS-1:0] alt_en,
  input  wire logic [pin_mux_pkg::NUM_ALT-1:0][pin_mux_pkg::NUM_PINS-1:0] alt_out,
  input  wire logic [pin_mux_pkg::NUM_ALT-1:0][pin_mux_pkg::NUM_PINS-1:0] alt_drive,
  output logic      [pin_mux_pkg::NUM_ALT-1:0][pin_mux_pkg::NUM_PINS-1:0] alt_in
);
  import pin_mux_pkg::*;

  localparam logic [NUM_ALT-1:0][NUM_PINS-1:0] ALT_PRESENT = {ALT4_PRESENT, ALT3_PRESENT,
                                                              ALT2_PRESENT, ALT1_PRESENT};

  // Pins the checks below watch; any pin of the same kind would serve, except open-drain pins 2 and 3 for the unpopulated-slot check
  localparam int HIDRIVE_CHK_PIN = 12;
  localparam int UNPOP_CHK_PIN   = 16;

  // Highest enabled slot wins; 0 means GPIO
  function automatic logic [2:0] owner_of(input logic [3:0] en);
    logic [2:0] o;
    o = OWNER_GPIO;
    if (en[3]) begin
      o = 3'h4;
    end else if (en[2]) begin
      o = 3'h3;
    end else if (en[1]) begin
      o = 3'h2;
    end else if (en[0]) begin
      o = 3'h1;
    end
    return o;
  endfunction

  // Merges a 32-bit word into the low or high part of a pin vector
  function automatic logic [NUM_PINS-1:0] merge(input logic [NUM_PINS-1:0] cur,
                                                input logic [31:0] w, input logic hi);
    logic [NUM_PINS-1:0] r;
    r = cur;
    if (hi) begin
      r[NUM_PINS-1:32] = w[NUM_PINS-33:0];
    end else begin
      r[31:0] = w;
    end
    return r;
  endfunction

  logic [NUM_PINS-1:0] data_q;
  logic [NUM_PINS-1:0] dir_q;
  logic [NUM_PINS-1:0] pull_q;
  logic [NUM_PINS-1:0] drive_q;
  logic [NUM_PINS-1:0] level_q;

  logic [NUM_PINS-1:0] drv_val;
  logic [NUM_PINS-1:0] drv_en;
  logic [NUM_PINS-1:0] oe_n_d;
  logic [NUM_PINS-1:0] pull_d;
  logic [NUM_PINS-1:0] hid_d;
  logic [NUM_ALT-1:0][NUM_PINS-1:0] alt_in_d;

  genvar gp;
  genvar gs;
  generate
    for (gp = 0; gp < NUM_PINS; gp++) begin : g_pin
      wire [3:0] en_ok;
      wire [2:0] own;
      wire       to_gpio;
      for (gs = 0; gs < NUM_ALT; gs++) begin : g_slot
        assign en_ok[gs] = alt_en[gs][gp] & ALT_PRESENT[gs][gp];
        // highest enable
        // Non-owners see a quiet low, so a takeover can look like an edge to them
        assign alt_in_d[gs][gp] = (own == 3'(gs + 1)) & pin_in[gp] & ~OUT_ONLY_MASK[gp];
      end
      assign own     = owner_of(en_ok);
      assign to_gpio = (own == OWNER_GPIO);
      assign drv_en[gp]  = to_gpio ? dir_q[gp] : alt_drive[3'(own - 3'h1)][gp];
      assign drv_val[gp] = to_gpio ? data_q[gp] : alt_out[3'(own - 3'h1)][gp];
    end
  endgenerate

  assign oe_n_d = ~(drv_en & (~drv_val | ~OPEN_DRAIN_MASK));
  // pullup on inputs
  // Open-drain pins keep the pullup while released so the line can rise
  assign pull_d = pull_q & ~OUT_ONLY_MASK & (~drv_en | (OPEN_DRAIN_MASK & drv_val));
  assign hid_d  = drive_q & HIGH_DRIVE_MASK & drv_en;

  wire hi_sel = addr[2];
  wire wr_data  = wr_stb & ((addr == REG_DATA_LO)  | (addr == REG_DATA_HI));
  wire wr_dir   = wr_stb & ((addr == REG_DIR_LO)   | (addr == REG_DIR_HI));
  wire wr_pull  = wr_stb & ((addr == REG_PULL_LO)  | (addr == REG_PULL_HI));
  wire wr_drive = wr_stb & ((addr == REG_DRIVE_LO) | (addr == REG_DRIVE_HI));

  function automatic logic [31:0] pick(input logic [NUM_PINS-1:0] v, input logic hi);
    return hi ? {{(64 - NUM_PINS){1'b0}}, v[NUM_PINS-1:32]} : v[31:0];
  endfunction

  logic [31:0] rd_word;
  always_comb begin
    rd_word = RDATA_RESET;
    unique case (addr)
      REG_DATA_LO, REG_DATA_HI:   rd_word = pick(data_q, hi_sel);
      REG_DIR_LO, REG_DIR_HI:     rd_word = pick(dir_q, hi_sel);
      REG_PULL_LO, REG_PULL_HI:   rd_word = pick(pull_q, hi_sel);
      REG_DRIVE_LO, REG_DRIVE_HI: rd_word = pick(drive_q, hi_sel);
      REG_LEVEL_LO, REG_LEVEL_HI: rd_word = pick(level_q, hi_sel);
      default:                    rd_word = RDATA_RESET;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      data_q  <= PIN_CFG_RESET;
      dir_q   <= PIN_CFG_RESET;
      pull_q  <= PIN_CFG_RESET;
      drive_q <= PIN_CFG_RESET;
    end else begin
      if (wr_data) begin
        data_q <= merge(data_q, wdata, hi_sel);
      end
      if (wr_dir) begin
        dir_q <= merge(dir_q, wdata, hi_sel);
      end
      if (wr_pull) begin
        pull_q <= merge(pull_q, wdata, hi_sel);
      end
      if (wr_drive) begin
        // Normal pins keep no high-drive bit, so a readback shows what applies
        drive_q <= merge(drive_q, wdata, hi_sel) & HIGH_DRIVE_MASK;
      end
    end
  end

  // Read data idle at zero outside the cycle after a read strobe
  // no input path
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      level_q <= PIN_CFG_RESET;
      rdata   <= RDATA_RESET;
    end else begin
      level_q <= pin_in & ~OUT_ONLY_MASK;
      rdata   <= rd_stb ? rd_word : RDATA_RESET;
    end
  end

  // Pin controls leave from flops: one cycle of latency, but no glitches at the pads
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pin_out     <= PIN_CFG_RESET;
      pin_oe_n    <= ~PIN_CFG_RESET;
      pin_pull_en <= PIN_CFG_RESET;
      pin_hidrive <= PIN_CFG_RESET;
      alt_in      <= '0;
    end else begin
      pin_out     <= drv_val & ~OPEN_DRAIN_MASK;
      pin_oe_n    <= oe_n_d;
      pin_pull_en <= pull_d;
      pin_hidrive <= hid_d;
      alt_in      <= alt_in_d;
    end
  end

  chk_outonly_no_input: assert property (@(posedge mclk) disable iff (!resetn)
    (alt_in[0][OUT_ONLY_PORT_PIN] | alt_in[1][OUT_ONLY_PORT_PIN] | alt_in[2][OUT_ONLY_PORT_PIN]
     | alt_in[3][OUT_ONLY_PORT_PIN] | level_q[OUT_ONLY_PORT_PIN]) == 1'b0)
    else $error("output-only pin shows an input path");

  chk_pull_input_only: assert property (@(posedge mclk) disable iff (!resetn)
    ##1 ((pin_pull_en & ~pin_oe_n & ~OPEN_DRAIN_MASK) == '0)
        && (pin_pull_en == ($past(pull_q) & ~OUT_ONLY_MASK
                            & (~$past(drv_en) | (OPEN_DRAIN_MASK & $past(drv_val))))))
    else $error("pullup state does not follow input use");

  chk_hidrive_out: assert property (@(posedge mclk) disable iff (!resetn)
    $past(drive_q[12]) && !pin_oe_n[12] |-> pin_hidrive[12])
    else $error("high drive missing on driven high-current pin");

  chk_hidrive_mask: assert property (@(posedge mclk) disable iff (!resetn)
    (pin_hidrive & (~HIGH_DRIVE_MASK | pin_oe_n)) == '0)
    else $error("high drive on a normal or undriven pin");

  chk_opendrain_low: assert property (@(posedge mclk) disable iff (!resetn)
    ((~pin_oe_n & pin_out & OPEN_DRAIN_MASK) == '0)
    and (!pin_oe_n[OPEN_DRAIN_PIN_A] |-> !pin_out[OPEN_DRAIN_PIN_A])
    and (!pin_oe_n[OPEN_DRAIN_PIN_B] |-> !pin_out[OPEN_DRAIN_PIN_B]))
    else $error("open-drain pin driven high");

  chk_reset_hiz: assert property (@(posedge mclk)
    !resetn |-> ##1 (&pin_oe_n && pin_pull_en == '0 && alt_in == '0))
    else $error("pins not released by reset");

  chk_prio_owner: assert property (@(posedge mclk) disable iff (!resetn)
    alt_en[3][FULL_ALT_CHK_PIN] && alt_en[0][FULL_ALT_CHK_PIN]
    |=> !alt_in[0][FULL_ALT_CHK_PIN] && alt_in[3][FULL_ALT_CHK_PIN] == $past(pin_in[FULL_ALT_CHK_PIN]))
    else $error("lower slot kept the pin");

  chk_slot_rank: assert property (@(posedge mclk) disable iff (!resetn)
    alt_en[2][FULL_ALT_CHK_PIN] && alt_en[1][FULL_ALT_CHK_PIN] && !alt_en[3][FULL_ALT_CHK_PIN]
    |=> pin_oe_n[FULL_ALT_CHK_PIN] == !$past(alt_drive[2][FULL_ALT_CHK_PIN]))
    else $error("slot 3 does not outrank slot 2");

  chk_gpio_return: assert property (@(posedge mclk) disable iff (!resetn)
    (alt_en[0][GPIO_ONLY_CHK_PIN] | alt_en[1][GPIO_ONLY_CHK_PIN] | alt_en[2][GPIO_ONLY_CHK_PIN]) == 1'b0
    |=> pin_oe_n[GPIO_ONLY_CHK_PIN] == !$past(dir_q[GPIO_ONLY_CHK_PIN])
        && pin_out[GPIO_ONLY_CHK_PIN] == $past(data_q[GPIO_ONLY_CHK_PIN]))
    else $error("pin not back under GPIO control");

  chk_fixed_table: assert property (@(posedge mclk) disable iff (!resetn)
    ##1 ((alt_in[0] & ~ALT1_PRESENT) | (alt_in[1] & ~ALT2_PRESENT)
         | (alt_in[2] & ~ALT3_PRESENT) | (alt_in[3] & ~ALT4_PRESENT)) == '0)
    else $error("unpopulated slot received the pin");

  chk_outonly_no_pull: assert property (@(posedge mclk) disable iff (!resetn)
    !pin_pull_en[OUT_ONLY_PORT_PIN])
    else $error("output-only pin has its pullup on");

  chk_level_sample: assert property (@(posedge mclk) disable iff (!resetn)
    $past(resetn) |-> level_q == ($past(pin_in) & ~OUT_ONLY_MASK))
    else $error("pin level register does not follow the pins");

  chk_pull_on_input: assert property (@(posedge mclk) disable iff (!resetn)
    pull_q[GPIO_ONLY_CHK_PIN] && !drv_en[GPIO_ONLY_CHK_PIN] |=> pin_pull_en[GPIO_ONLY_CHK_PIN])
    else $error("pullup missing on an input pin");

  chk_drive_reg_mask: assert property (@(posedge mclk) disable iff (!resetn)
    (drive_q & ~HIGH_DRIVE_MASK) == '0)
    else $error("high drive stored for a normal pin");

  chk_opendrain_out_zero: assert property (@(posedge mclk) disable iff (!resetn)
    (pin_out & OPEN_DRAIN_MASK) == '0)
    else $error("open-drain pin shows a high output level");

  chk_reset_regs: assert property (@(posedge mclk)
    !resetn |-> ##1 (data_q == PIN_CFG_RESET && dir_q == PIN_CFG_RESET && pull_q == PIN_CFG_RESET
                     && drive_q == PIN_CFG_RESET && rdata == RDATA_RESET))
    else $error("configuration not cleared by reset");

  chk_top_slot_drives: assert property (@(posedge mclk) disable iff (!resetn)
    alt_en[3][FULL_ALT_CHK_PIN]
    |=> pin_oe_n[FULL_ALT_CHK_PIN] == !$past(alt_drive[3][FULL_ALT_CHK_PIN])
        && pin_out[FULL_ALT_CHK_PIN] == $past(alt_out[3][FULL_ALT_CHK_PIN]))
    else $error("top slot does not drive its pin");

  chk_slot2_over_slot1: assert property (@(posedge mclk) disable iff (!resetn)
    alt_en[1][FULL_ALT_CHK_PIN] && alt_en[0][FULL_ALT_CHK_PIN]
    && !alt_en[2][FULL_ALT_CHK_PIN] && !alt_en[3][FULL_ALT_CHK_PIN]
    |=> pin_out[FULL_ALT_CHK_PIN] == $past(alt_out[1][FULL_ALT_CHK_PIN]) && !alt_in[0][FULL_ALT_CHK_PIN])
    else $error("slot 2 does not outrank slot 1");

  chk_loser_input_low: assert property (@(posedge mclk) disable iff (!resetn)
    alt_en[3][FULL_ALT_CHK_PIN]
    |=> !alt_in[0][FULL_ALT_CHK_PIN] && !alt_in[1][FULL_ALT_CHK_PIN] && !alt_in[2][FULL_ALT_CHK_PIN])
    else $error("a lower slot still sees the pin");

  chk_owner_gets_level: assert property (@(posedge mclk) disable iff (!resetn)
    alt_en[0][FULL_ALT_CHK_PIN] && !alt_en[1][FULL_ALT_CHK_PIN]
    && !alt_en[2][FULL_ALT_CHK_PIN] && !alt_en[3][FULL_ALT_CHK_PIN]
    |=> alt_in[0][FULL_ALT_CHK_PIN] == $past(pin_in[FULL_ALT_CHK_PIN]))
    else $error("owning slot does not see the pin level");

  chk_unpop_ignored: assert property (@(posedge mclk) disable iff (!resetn)
    alt_en[3][UNPOP_CHK_PIN] && !alt_en[2][UNPOP_CHK_PIN]
    && !alt_en[1][UNPOP_CHK_PIN] && !alt_en[0][UNPOP_CHK_PIN]
    |=> !alt_in[3][UNPOP_CHK_PIN] && pin_oe_n[UNPOP_CHK_PIN] == !$past(dir_q[UNPOP_CHK_PIN]))
    else $error("enable on an empty slot took the pin");

  chk_hidrive_slot_out: assert property (@(posedge mclk) disable iff (!resetn)
    alt_en[1][HIDRIVE_CHK_PIN] && alt_drive[1][HIDRIVE_CHK_PIN]
    && !alt_en[2][HIDRIVE_CHK_PIN] && drive_q[HIDRIVE_CHK_PIN]
    |=> pin_hidrive[HIDRIVE_CHK_PIN])
    else $error("peripheral output lost its high drive");
endmodule

// File: rtl/pin_mux_pkg.sv
// Constants shared by the port pin function multiplexer
package pin_mux_pkg;
  localparam int NUM_PINS = 37;
  localparam int NUM_ALT  = 4;
  localparam int AW       = 8;

  // Pin indices: port A 0..7, B 8..15, C 16..23, D 24..31, E 32..36
  localparam int OUT_ONLY_PORT_PIN = 4;
  localparam int OPEN_DRAIN_PIN_A  = 2;
  localparam int OPEN_DRAIN_PIN_B  = 3;
  localparam int GPIO_ONLY_CHK_PIN = 8;
  localparam int FULL_ALT_CHK_PIN  = 0;

  localparam logic [NUM_PINS-1:0] OUT_ONLY_MASK   = 37'h00_0000_0010;
  localparam logic [NUM_PINS-1:0] OPEN_DRAIN_MASK = 37'h00_0000_000C;
  localparam logic [NUM_PINS-1:0] HIGH_DRIVE_MASK = 37'h00_0300_3000;

  // Fixed slot population per pin, slot 1 lowest priority, slot 4 highest
  localparam logic [NUM_PINS-1:0] ALT1_PRESENT = 37'h00_0000_0F2F;
  localparam logic [NUM_PINS-1:0] ALT2_PRESENT = 37'h1F_03FF_3FFF;
  localparam logic [NUM_PINS-1:0] ALT3_PRESENT = 37'h00_000F_FFDF;
  localparam logic [NUM_PINS-1:0] ALT4_PRESENT = 37'h00_0000_C033;

  // Register byte addresses, one 32-bit word each
  localparam logic [AW-1:0] REG_DATA_LO  = 8'h00;
  localparam logic [AW-1:0] REG_DATA_HI  = 8'h04;
  localparam logic [AW-1:0] REG_DIR_LO   = 8'h08;
  localparam logic [AW-1:0] REG_DIR_HI   = 8'h0C;
  localparam logic [AW-1:0] REG_PULL_LO  = 8'h10;
  localparam logic [AW-1:0] REG_PULL_HI  = 8'h14;
  localparam logic [AW-1:0] REG_DRIVE_LO = 8'h18;
  localparam logic [AW-1:0] REG_DRIVE_HI = 8'h1C;
  localparam logic [AW-1:0] REG_LEVEL_LO = 8'h20;
  localparam logic [AW-1:0] REG_LEVEL_HI = 8'h24;

  localparam logic [NUM_PINS-1:0] PIN_CFG_RESET = 37'h00_0000_0000;
  localparam logic [31:0]         RDATA_RESET   = 32'h0000_0000;
  localparam logic [2:0]          OWNER_GPIO    = 3'h0;
endpackage

// File: sim/periph_model.sv
// Peripheral side model driving the alternate slot controls
`timescale 1ns/1ps
module periph_model
  import pin_mux_pkg::*;
(
  input  wire logic                          mclk,
  output logic [NUM_ALT-1:0][NUM_PINS-1:0]   alt_en,
  output logic [NUM_ALT-1:0][NUM_PINS-1:0]   alt_out,
  output logic [NUM_ALT-1:0][NUM_PINS-1:0]   alt_drive,
  input  wire logic [NUM_ALT-1:0][NUM_PINS-1:0] alt_in
);
  logic [NUM_ALT-1:0][NUM_PINS-1:0] in_q      = '0;
  logic [NUM_ALT-1:0][NUM_PINS-1:0] edge_flag = '0;
  logic                             clr_q     = 1'b0;
  initial begin
    alt_en    = '0;
    alt_out   = '0;
    alt_drive = '0;
  end
  // any change of a delivered input is latched as a module flag
  // a loser's falling input counts too; a set wins over a clear
  always @(posedge mclk) begin
    in_q      <= alt_in;
    edge_flag <= (clr_q ? '0 : edge_flag) | (alt_in ^ in_q);
  end
  // flags cleared at the second rising edge after the call, by a one-cycle clr_q pulse
  task automatic clear_flags();
    @(posedge mclk);
    clr_q <= 1'b1;
    @(posedge mclk);
    clr_q <= 1'b0;
  endtask
  // Controls change only just after a rising edge
  task automatic set_slot(input int s, input int p, input logic en, input logic drv, input logic val);
    @(posedge mclk);
    alt_en[s][p]    <= en;
    alt_drive[s][p] <= drv;
    alt_out[s][p]   <= drv ? val : ~val;
  endtask
  // all sharers off before a new owner
  // module flags are not cleared by the caller after this
  task automatic clear_all();
    @(posedge mclk);
    alt_en    <= '0;
    alt_drive <= '0;
    alt_out   <= ~alt_out;
  endtask
endmodule

// File: sim/port_pin_function_mux_tb.sv
// Self-checking bench for the port pin function multiplexer
`timescale 1ns/1ps
module port_pin_function_mux_tb;
  import pin_mux_pkg::*;
  logic                             mclk = 1'b0;
  logic                             resetn = 1'b0;
  logic [AW-1:0]                    addr = '0;
  logic [31:0]                      wdata = '0;
  logic                             wr_stb = 1'b0;
  logic                             rd_stb = 1'b0;
  logic [31:0]                      rdata;
  logic [NUM_PINS-1:0]              pin_in = 37'h15_5555_5557;
  logic [NUM_PINS-1:0]              pin_out, pin_oe_n, pin_pull_en, pin_hidrive;
  logic [NUM_ALT-1:0][NUM_PINS-1:0] alt_en, alt_out, alt_drive, alt_in;
  int                               error_cnt = 0;
  int                               comparisons = 0;
  int                               cycles = 0;
  logic [31:0]                      d;

  port_pin_function_mux u_dut (.mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_pull_en(pin_pull_en), .pin_hidrive(pin_hidrive), .alt_en(alt_en), .alt_out(alt_out),
    .alt_drive(alt_drive), .alt_in(alt_in));
  periph_model u_periph (.mclk(mclk), .alt_en(alt_en), .alt_out(alt_out), .alt_drive(alt_drive),
    .alt_in(alt_in));

  initial begin
    forever #5 mclk = ~mclk;
  end
  // Ceiling well above the roughly 100 cycles the tests use
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic chk(input logic [4*NUM_PINS-1:0] seen, input logic [4*NUM_PINS-1:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [31:0] v);
    @(posedge mclk);
    wr_stb <= 1'b1;
    addr   <= a;
    wdata  <= v;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [AW-1:0] a, output logic [31:0] v);
    @(posedge mclk);
    rd_stb <= 1'b1;
    addr   <= a;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic settle();
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    settle();
    chk({pin_oe_n, pin_pull_en}, {37'h1F_FFFF_FFFF, 37'h0});
    chk({pin_out, pin_hidrive}, '0);
    chk(alt_in, '0);
    u_periph.clear_flags();
    settle();
    chk(u_periph.edge_flag, '0);
    $display("test reset done");
    // Level register, read-only and unmapped places
    for (int i = 0; i < 2; i++) begin
      rd(REG_LEVEL_LO, d);
      chk(d, 32'h5555_5547);
      wr(REG_LEVEL_LO, 32'hFFFF_FFFF);
      wr(8'h40, 32'hFFFF_FFFF);
      rd(8'h40, d);
      chk(d, 32'h0);
    end
    wr(REG_DIR_LO, 32'h0000_001F);
    wr(REG_DATA_LO, 32'h0000_0015);
    settle();
    chk(pin_out[4:0], 5'b10001);
    chk(pin_oe_n[4:0], 5'b00100);
    $display("test gpio done");
    wr(REG_DIR_LO, 32'h0);
    wr(REG_PULL_LO, 32'hFFFF_FFFF);
    wr(REG_PULL_HI, 32'hFFFF_FFFF);
    settle();
    chk(pin_pull_en, 37'h1F_FFFF_FFEF);
    rd(REG_PULL_HI, d);
    chk(d, 32'h0000_001F);
    $display("test pull done");
    wr(REG_DIR_LO, 32'hFFFF_FFFF);
    wr(REG_DIR_HI, 32'hFFFF_FFFF);
    wr(REG_DRIVE_LO, 32'hFFFF_FFFF);
    settle();
    chk(pin_hidrive, HIGH_DRIVE_MASK);
    rd(REG_DRIVE_LO, d);
    chk(d, HIGH_DRIVE_MASK[31:0]);
    wr(REG_DIR_LO, 32'h0);
    wr(REG_DIR_HI, 32'h0);
    $display("test drive done");
    // Each higher slot is added while the lower ones stay enabled
    for (int k = 0; k < NUM_ALT; k++) begin
      if (k > 0)
        u_periph.set_slot(k - 1, FULL_ALT_CHK_PIN, 1'b1, 1'b1, 1'b0);
      u_periph.set_slot(k, FULL_ALT_CHK_PIN, 1'b1, 1'b1, 1'b1);
      settle();
      chk({pin_out[0], pin_oe_n[0]}, 2'b10);
      chk({alt_in[3][0], alt_in[2][0], alt_in[1][0], alt_in[0][0]}, 4'b0001 << k);
      chk(u_periph.edge_flag[k][0], 1'b1);
      if (k > 0)
        chk(u_periph.edge_flag[k - 1][0], 1'b1);
      u_periph.clear_flags();
      settle();
      chk(u_periph.edge_flag, '0);
    end
    u_periph.set_slot(1, 12, 1'b1, 1'b1, 1'b1);
    settle();
    chk(pin_hidrive[13:12], 2'b01);
    u_periph.clear_all();
    settle();
    chk({pin_oe_n[0], alt_in[3][0]}, 2'b10);
    u_periph.set_slot(3, 16, 1'b1, 1'b1, 1'b1);
    settle();
    chk({pin_oe_n[16], alt_in[3][16]}, 2'b10);
    $display("test priority done");
    give_verdict();
  end
endmodule
